// ==== acc_analog_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module acc_analog_model (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire acc_pkg::acc_ain_s [acc_pkg::ACC_NCH-1:0] tgt,
  input  wire logic [3:0]                           lag,
  input  wire logic [acc_pkg::ACC_NCH-1:0]          adc_trig,
  output var acc_pkg::acc_ain_s [acc_pkg::ACC_NCH-1:0]  ain,
  output var logic [acc_pkg::ACC_NCH-1:0][7:0]      trig_cnt
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // pin voltages and trigger receiver
  // ----------------------------------------------------------------
  logic [3:0] wait_ff;

  // sources settle after an adjustable lag, so slow analog edges can be mimicked
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wait_ff  <= 4'h0;
      trig_cnt <= '0;
      ain      <= '0;
    end
    else
    begin
      if (tgt != ain)
      begin
        if (wait_ff >= lag)
        begin
          ain     <= tgt;
          wait_ff <= 4'h0;
        end
        else
        begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
      // the sequencer sees every single-cycle trigger pulse
      for (int i = 0; i < ACC_NCH; i++)
      begin
        if (adc_trig[i])
        begin
          trig_cnt[i] <= trig_cnt[i] + 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== acc_pkg.sv ====
// Function
// RULE1: two independent channels, each fully self-contained; here both share one ladder and channel 1 can use channel 0's positive pin
// RULE2: result high when negative below positive
// RULE3: negative from pin; positive source selectable
// RULE4: result drives pin, interrupt, or ADC trigger
// RULE5: interrupt and trigger have separate edge logic
// RULE6: output pins stay GPIO until alternate chosen
// RULE7: a channel may lack an output pin
// RULE8: software selects positive source before use
// RULE9: ladder off gives ground reference
// RULE10: high range uses tap over 23
// RULE11: low range uses tap plus 8 over 31
// RULE12: status register shows current output level
// RULE13: interrupt reaches processor only when enabled
// RULE14: write one clears pending, zero keeps
// RULE15: result synchronised by two stages first
`default_nettype none

package acc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int ACC_NCH = 2;
  localparam int ACC_VW  = 12;
  localparam int ACC_FS  = 4096; // full-scale code, stands for the analog supply

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_OFF_MIS    = 8'h00;
  localparam logic [7:0] ACC_OFF_RIS    = 8'h04;
  localparam logic [7:0] ACC_OFF_INTEN  = 8'h08;
  localparam logic [7:0] ACC_OFF_REFCTL = 8'h10;
  localparam logic [7:0] ACC_OFF_STAT0  = 8'h20;
  localparam logic [7:0] ACC_OFF_CTL0   = 8'h24;
  localparam logic [7:0] ACC_OFF_CHSTEP = 8'h20;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          ACC_CTL_W       = 12;
  localparam logic [11:0] ACC_CTL_WMASK   = 12'hEFE;
  localparam logic [11:0] ACC_CTL_RST     = 12'h000;
  localparam int          ACC_REF_W       = 10;
  localparam logic [9:0]  ACC_REF_WMASK   = 10'h30F;
  localparam logic [9:0]  ACC_REF_RST     = 10'h000;
  localparam int          ACC_STAT_LVL_BIT = 1;

  // ----------------------------------------------------------------
  // reference ladder
  // ----------------------------------------------------------------
  localparam int ACC_LADDER_HI  = 23;
  localparam int ACC_LADDER_LO  = 31;
  localparam int ACC_LADDER_OFS = 8;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_SENSE_LEVEL, ACC_SENSE_FALL, ACC_SENSE_RISE, ACC_SENSE_BOTH}
    acc_sense_e;
  typedef enum logic [1:0] {ACC_SRC_OWN, ACC_SRC_CMP0, ACC_SRC_REF, ACC_SRC_RSVD} acc_src_e;

  typedef struct packed {
    logic       toen;
    acc_src_e   pss;
    logic       rsv8;
    logic       tslval;
    acc_sense_e tsen;
    logic       islval;
    acc_sense_e isen;
    logic       inv;
    logic       rsv0;
  } acc_ctl_s;

  typedef struct packed {
    logic       en;
    logic       range_select;
    logic [3:0] rsv;
    logic [3:0] tap;
  } acc_ref_s;

  // one channel's analog pins, as codes of the full-scale supply
  typedef struct packed {
    logic [ACC_VW-1:0] neg;
    logic [ACC_VW-1:0] pos;
  } acc_ain_s;

endpackage

`default_nettype wire

// ==== acc_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module acc_top #(
  parameter logic [acc_pkg::ACC_NCH-1:0] HAS_PIN = 2'b11
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic                                 wb_cyc_i,
  input  wire logic                                 wb_stb_i,
  input  wire logic                                 wb_we_i,
  input  wire logic [7:0]                           wb_adr_i,
  input  wire logic [3:0]                           wb_sel_i,
  input  wire logic [31:0]                          wb_dat_i,
  output logic [31:0]                               wb_dat_o,
  output logic                                      wb_ack_o,
  input  wire acc_pkg::acc_ain_s [acc_pkg::ACC_NCH-1:0] ain,
  input  wire logic [acc_pkg::ACC_NCH-1:0]          alt_function_choice,
  input  wire logic [acc_pkg::ACC_NCH-1:0]          gpio_out,
  input  wire logic [acc_pkg::ACC_NCH-1:0]          gpio_oe,
  output logic [acc_pkg::ACC_NCH-1:0]               cmp_pin_o,
  output logic [acc_pkg::ACC_NCH-1:0]               cmp_pin_oe,
  output logic [acc_pkg::ACC_NCH-1:0]               adc_trig_o,
  output logic                                      irq_o
);
  import acc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    acc_ctl_s [ACC_NCH-1:0] ctl;
    acc_ref_s               refctl;
    logic [ACC_NCH-1:0]     inten;
    logic [ACC_NCH-1:0]     ris;
    logic [ACC_NCH-1:0]     sync1;
    logic [ACC_NCH-1:0]     sync2;
    logic [ACC_NCH-1:0]     prev;
    logic [ACC_NCH-1:0]     pin;
    logic [ACC_NCH-1:0]     pin_oe;
    logic [ACC_NCH-1:0]     trig;
    logic                   ack;
    logic [31:0]            rdata;
  } acc_state_s;

  acc_state_s           st_ff;
  acc_state_s           nxt_st;
  logic [ACC_VW-1:0]    ref_code;
  logic [ACC_NCH-1:0]   raw_cmp;
  logic [ACC_NCH-1:0]   cur_lvl;
  logic [31:0]          rd_word;
  logic                 req;
  logic [ACC_NCH-1:0]   evt_int;
  logic [ACC_NCH-1:0]   evt_trg;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // edge or level qualifier, shared by interrupt and trigger paths
  function automatic logic acc_edge(input acc_sense_e sense, input logic lvl,
                                    input logic cur, input logic prv);
    logic r;
    case (sense)
      ACC_SENSE_LEVEL: r = (cur == lvl);
      ACC_SENSE_FALL:  r = prv & ~cur;
      ACC_SENSE_RISE:  r = ~prv & cur;
      default:         r = prv ^ cur;
    endcase
    return r;
  endfunction

  // ladder tap as a full-scale code; off means ground
  function automatic logic [ACC_VW-1:0] acc_ref(input acc_ref_s r);
    logic [31:0] num;
    if (!r.en)
      num = 32'h0;  // RULE9
    else if (r.range_select)
      num = (32'(r.tap) * ACC_FS) / ACC_LADDER_HI;  // RULE10
    else
      num = ((32'(r.tap) + ACC_LADDER_OFS) * ACC_FS) / ACC_LADDER_LO;  // RULE11
    return num[ACC_VW-1:0];
  endfunction

  // byte-lane merge of write data over the old word
  function automatic logic [31:0] acc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction

  // address decode, used for reads and writes alike
  function automatic logic acc_hit(input logic [7:0] adr, input logic [7:0] off);
    return {adr[7:2], 2'b00} == off;
  endfunction

  // ----------------------------------------------------------------
  // analog front end model
  // ----------------------------------------------------------------
  assign ref_code = acc_ref(st_ff.refctl);

  // the compare is the asynchronous core; nothing clocked reads it before sync1
  for (genvar ch = 0; ch < ACC_NCH; ch++)
  begin : g_chan
    logic [ACC_VW-1:0] pos_sel;
    // negative always from its own pin, positive per select
    always_comb
    begin
      case (st_ff.ctl[ch].pss)
        ACC_SRC_CMP0: pos_sel = ain[0].pos;  // RULE3
        ACC_SRC_REF:  pos_sel = ref_code;  // RULE3
        default:      pos_sel = ain[ch].pos;  // RULE3
      endcase
    end
    assign raw_cmp[ch] = (ain[ch].neg < pos_sel);  // RULE2
    assign cur_lvl[ch] = st_ff.sync2[ch] ^ st_ff.ctl[ch].inv;  // RULE1
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h0;  // unmapped and reserved read as zero
    if (acc_hit(wb_adr_i, ACC_OFF_MIS))
      rd_word[ACC_NCH-1:0] = st_ff.ris & st_ff.inten;
    else if (acc_hit(wb_adr_i, ACC_OFF_RIS))
      rd_word[ACC_NCH-1:0] = st_ff.ris;
    else if (acc_hit(wb_adr_i, ACC_OFF_INTEN))
      rd_word[ACC_NCH-1:0] = st_ff.inten;
    else if (acc_hit(wb_adr_i, ACC_OFF_REFCTL))
      rd_word[ACC_REF_W-1:0] = st_ff.refctl;
    for (int ch = 0; ch < ACC_NCH; ch++)
    begin
      if (acc_hit(wb_adr_i, ACC_OFF_STAT0 + 8'(ch) * ACC_OFF_CHSTEP))
        rd_word[ACC_STAT_LVL_BIT] = cur_lvl[ch];  // RULE12
      if (acc_hit(wb_adr_i, ACC_OFF_CTL0 + 8'(ch) * ACC_OFF_CHSTEP))
        rd_word[ACC_CTL_W-1:0] = st_ff.ctl[ch];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one always_comb holds the bus slave, event logic and pin muxing
  always_comb
  begin
    logic [31:0] wr_word;
    logic [ACC_NCH-1:0] clr;
    nxt_st  = st_ff;
    wr_word = acc_merge(rd_word, wb_dat_i, wb_sel_i);
    clr     = '0;
    evt_int = '0;
    evt_trg = '0;

    // two-stage synchroniser, then one stage of history for edges
    nxt_st.sync1 = raw_cmp;  // RULE15
    nxt_st.sync2 = st_ff.sync1;  // RULE15
    nxt_st.prev  = st_ff.sync2;

    // classic single-cycle answer; ack drops the cycle after it is given
    req          = wb_cyc_i && wb_stb_i && !st_ff.ack;
    nxt_st.ack   = req;
    if (req && !wb_we_i)
      nxt_st.rdata = rd_word;

    if (req && wb_we_i)
    begin
      if (acc_hit(wb_adr_i, ACC_OFF_MIS) && wb_sel_i[0])
        clr = wb_dat_i[ACC_NCH-1:0];  // RULE14
      if (acc_hit(wb_adr_i, ACC_OFF_INTEN))
        nxt_st.inten = wr_word[ACC_NCH-1:0];
      if (acc_hit(wb_adr_i, ACC_OFF_REFCTL))
        nxt_st.refctl = acc_ref_s'(wr_word[ACC_REF_W-1:0] & ACC_REF_WMASK);
      for (int ch = 0; ch < ACC_NCH; ch++)
        if (acc_hit(wb_adr_i, ACC_OFF_CTL0 + 8'(ch) * ACC_OFF_CHSTEP))
          nxt_st.ctl[ch] = acc_ctl_s'(wr_word[ACC_CTL_W-1:0] & ACC_CTL_WMASK);  // RULE8
    end

    // separate qualifiers: interrupt on one edge, trigger on another
    for (int ch = 0; ch < ACC_NCH; ch++)
    begin
      evt_int[ch] = acc_edge(st_ff.ctl[ch].isen, st_ff.ctl[ch].islval, cur_lvl[ch],
                             st_ff.prev[ch] ^ st_ff.ctl[ch].inv);  // RULE5
      evt_trg[ch] = st_ff.ctl[ch].toen &
                    acc_edge(st_ff.ctl[ch].tsen, st_ff.ctl[ch].tslval, cur_lvl[ch],
                             st_ff.prev[ch] ^ st_ff.ctl[ch].inv);  // RULE5
      // pin carries the result only with the alternate function and a pin present
      if (HAS_PIN[ch] && alt_function_choice[ch])
      begin
        nxt_st.pin[ch]    = cur_lvl[ch];  // RULE4
        nxt_st.pin_oe[ch] = 1'b1;
      end
      else
      begin
        nxt_st.pin[ch]    = gpio_out[ch];  // RULE6 RULE7
        nxt_st.pin_oe[ch] = gpio_oe[ch];
      end
    end

    // a new event beats a clear in the same cycle
    nxt_st.ris  = (st_ff.ris & ~clr) | evt_int;  // RULE14
    nxt_st.trig = evt_trg;  // RULE4
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o   = st_ff.rdata;
  assign wb_ack_o   = st_ff.ack;
  assign cmp_pin_o  = st_ff.pin;
  assign cmp_pin_oe = st_ff.pin_oe;
  assign adc_trig_o = st_ff.trig;
  assign irq_o      = |(st_ff.ris & st_ff.inten);  // RULE13

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic wr_mis;
  logic wr_inten;
  assign wr_mis   = req && wb_we_i && acc_hit(wb_adr_i, ACC_OFF_MIS) && wb_sel_i[0];
  // an enable write in flight changes the next mask, so it is left out below
  assign wr_inten = req && wb_we_i && acc_hit(wb_adr_i, ACC_OFF_INTEN);

  property p_irq_masked;
    @(posedge clk) disable iff (reset)
      (st_ff.inten == '0 && !wr_inten) |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq without enable");  // RULE13

  property p_irq_raw;
    @(posedge clk) disable iff (reset)
      (evt_int[0] && st_ff.inten[0] && !wr_inten) |=> irq_o;
  endproperty
  a_irq_raw: assert property (p_irq_raw) else $error("enabled pending not signalled");  // RULE13

  property p_w1c;
    @(posedge clk) disable iff (reset)
      (wr_mis && wb_dat_i[0] && !evt_int[0]) |=> !st_ff.ris[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");  // RULE14

  property p_w0;
    @(posedge clk) disable iff (reset)
      (wr_mis && !wb_dat_i[0] && st_ff.ris[0]) |=> st_ff.ris[0];
  endproperty
  a_w0: assert property (p_w0) else $error("write zero cleared pending");  // RULE14

  property p_sync;
    @(posedge clk) disable iff (reset)
      raw_cmp[0] [*3] |-> st_ff.sync2[0];
  endproperty
  a_sync: assert property (p_sync) else $error("result not through two stages");  // RULE15

  property p_ref_gnd;
    @(posedge clk) disable iff (reset)
      !st_ff.refctl.en |-> (ref_code == '0);
  endproperty
  a_ref_gnd: assert property (p_ref_gnd) else $error("ladder off not ground");  // RULE9

  property p_ref_hi;
    @(posedge clk) disable iff (reset)
      (st_ff.refctl.en && st_ff.refctl.range_select && st_ff.refctl.tap == 4'hF)
        |-> (ref_code == 12'hA6F);
  endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("high range tap wrong");  // RULE10

  property p_ref_lo;
    @(posedge clk) disable iff (reset)
      (st_ff.refctl.en && !st_ff.refctl.range_select && st_ff.refctl.tap == 4'h0)
        |-> (ref_code == 12'h421);
  endproperty
  a_ref_lo: assert property (p_ref_lo) else $error("low range offset wrong");  // RULE11

  property p_pin_gpio;
    @(posedge clk) disable iff (reset)
      !alt_function_choice[0] |=> (cmp_pin_o[0] == $past(gpio_out[0]));
  endproperty
  a_pin_gpio: assert property (p_pin_gpio) else $error("pin left GPIO function");  // RULE6

  property p_sep_edges;
    @(posedge clk) disable iff (reset)
      (st_ff.ctl[0].isen == ACC_SENSE_RISE && st_ff.ctl[0].tsen == ACC_SENSE_FALL &&
       st_ff.ctl[0].toen && !st_ff.ctl[0].inv && $rose(st_ff.sync2[0]))
        |=> (st_ff.ris[0] && !adc_trig_o[0]);
  endproperty
  a_sep_edges: assert property (p_sep_edges) else $error("trigger followed interrupt edge");  // RULE5

  property p_stat;
    @(posedge clk) disable iff (reset)
      (req && !wb_we_i && acc_hit(wb_adr_i, ACC_OFF_STAT0))
        |=> (wb_dat_o[ACC_STAT_LVL_BIT] == $past(cur_lvl[0]));
  endproperty
  a_stat: assert property (p_stat) else $error("status level wrong");  // RULE12

  // ack is a single pulse; a request held past it is taken again every second cycle
  property p_ack_pulse;
    @(posedge clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

  property p_pin_alt;
    @(posedge clk) disable iff (reset)
      (HAS_PIN[0] && alt_function_choice[0])
        |=> (cmp_pin_o[0] == $past(cur_lvl[0]) && cmp_pin_oe[0]);
  endproperty
  a_pin_alt: assert property (p_pin_alt) else $error("alternate pin not result");  // RULE4

  // a missing pin must keep the gpio value whatever the select says
  property p_pin_absent;
    @(posedge clk) disable iff (reset)
      !HAS_PIN[1] |=> (cmp_pin_o[1] == $past(gpio_out[1]));
  endproperty
  a_pin_absent: assert property (p_pin_absent) else $error("absent pin driven by result");  // RULE7

  property p_trig_fall;
    @(posedge clk) disable iff (reset)
      (st_ff.ctl[0].toen && st_ff.ctl[0].tsen == ACC_SENSE_FALL && !st_ff.ctl[0].inv &&
       $fell(st_ff.sync2[0]))
        |=> adc_trig_o[0];
  endproperty
  a_trig_fall: assert property (p_trig_fall) else $error("falling edge gave no trigger");  // RULE4

  property p_trig_off;
    @(posedge clk) disable iff (reset)
      !st_ff.ctl[0].toen |=> !adc_trig_o[0];
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");  // RULE4

  property p_both;
    @(posedge clk) disable iff (reset)
      (st_ff.ctl[0].isen == ACC_SENSE_BOTH && st_ff.sync2[0] != st_ff.prev[0])
        |=> st_ff.ris[0];
  endproperty
  a_both: assert property (p_both) else $error("both-edge event not recorded");  // RULE5

endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import acc_pkg::*;

  typedef struct packed {
    logic        ch;
    logic [11:0] ctl;
    logic [9:0]  rf;
    logic [11:0] neg;
    logic [11:0] p0;
    logic [11:0] p1;
  } acc_tb_row_s;

  logic                   clk, reset, cyc, stb, we, ack, irq;
  logic [7:0]             adr;
  logic [3:0]             sel, lag;
  logic [31:0]            wdat, rdat, q;
  acc_ain_s [ACC_NCH-1:0] tgt, ain;
  logic [1:0]             alt, gout, goe, pin, pin_oe, trig;
  logic [1:0][7:0]        tcnt;
  logic [7:0]             t0;
  int                     fails, comparisons;
  logic [7:0]             zregs [7] = '{8'h08, 8'h10, 8'h20, 8'h24, 8'h40, 8'h44, 8'h80};
  acc_tb_row_s            rows [12] = '{
    '{1'b0, 12'h000, 10'h000, 12'h064, 12'h0C8, 12'h000},
    '{1'b0, 12'h002, 10'h000, 12'h064, 12'h0C8, 12'h000},
    '{1'b0, 12'h000, 10'h000, 12'h12C, 12'h0C8, 12'h000},
    '{1'b1, 12'h000, 10'h000, 12'h064, 12'h384, 12'h032},
    '{1'b1, 12'h200, 10'h000, 12'h064, 12'h384, 12'h032},
    '{1'b1, 12'h600, 10'h000, 12'h00A, 12'h000, 12'h014},
    '{1'b1, 12'h400, 10'h30F, 12'hA6E, 12'h000, 12'h000},
    '{1'b1, 12'h400, 10'h30F, 12'hA6F, 12'hFFF, 12'hFFF},
    '{1'b0, 12'h400, 10'h200, 12'h420, 12'h000, 12'h000},
    '{1'b0, 12'h400, 10'h200, 12'h421, 12'hFFF, 12'h000},
    '{1'b0, 12'h400, 10'h20F, 12'hBDD, 12'h000, 12'h000},
    '{1'b0, 12'h400, 10'h10F, 12'h000, 12'hFFF, 12'h000}};

  acc_top #(.HAS_PIN(2'b01)) u_acc_top (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ain(ain), .alt_function_choice(alt),
    .gpio_out(gout), .gpio_oe(goe), .cmp_pin_o(pin), .cmp_pin_oe(pin_oe),
    .adc_trig_o(trig), .irq_o(irq));

  acc_analog_model u_acc_analog_model (.clk(clk), .reset(reset), .tgt(tgt), .lag(lag),
    .adc_trig(trig), .ain(ain), .trig_cnt(tcnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // status level from the pins, source and ladder settings of a row
  function automatic logic exp_lvl(acc_tb_row_s r);
    int rv;
    int pos;
    rv = !r.rf[9] ? 0 : r.rf[8] ? int'(r.rf[3:0]) * ACC_FS / ACC_LADDER_HI
                                : (int'(r.rf[3:0]) + ACC_LADDER_OFS) * ACC_FS / ACC_LADDER_LO;
    case (r.ctl[10:9])
      2'h1:    pos = int'(r.p0);
      2'h2:    pos = rv;
      default: pos = r.ch ? int'(r.p1) : int'(r.p0);
    endcase
    return (int'(r.neg) < pos) ^ r.ctl[1];
  endfunction

  task automatic results();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // one classic cycle; entered just after a rising edge, leaves one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1)
    begin
      fails++;
      results();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rst_dut();
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset, cyc, stb, we, adr, sel, wdat} = '0;
    {tgt, lag, alt, gout, goe} = '0;
    reset = 1'b1;
    fails = 0;
    comparisons = 0;
    rst_dut();
    // ordinary cases: source, ladder and polarity per row
    foreach (rows[i])
    begin
      wr(ACC_OFF_REFCTL, {22'h0, rows[i].rf});
      wr(8'(ACC_OFF_CTL0 + rows[i].ch * ACC_OFF_CHSTEP), {20'h0, rows[i].ctl});
      tgt[0].neg <= rows[i].ch ? 12'h000 : rows[i].neg;
      tgt[0].pos <= rows[i].p0;
      tgt[1].neg <= rows[i].ch ? rows[i].neg : 12'h000;
      tgt[1].pos <= rows[i].p1;
      repeat (6) @(posedge clk);
      bus(1'b0, 8'(ACC_OFF_STAT0 + rows[i].ch * ACC_OFF_CHSTEP), 32'h0, q);
      chk(q, {30'h0, exp_lvl(rows[i]), 1'b0}, "level");
    end
    // mid-run reset, then read-only and unmapped writes are ignored
    tgt <= '0;
    rst_dut();
    chk({30'h0, pin_oe}, {30'h0, goe}, "gpio oe after reset");
    wr(ACC_OFF_STAT0, 32'hFFFF_FFFF);
    wr(8'h80, 32'hFFFF_FFFF);
    foreach (zregs[i])
    begin
      bus(1'b0, zregs[i], 32'h0, q);
      chk(q, 32'h0, "reset value");
    end
    // pins: gpio until alternate chosen, channel 1 has no pin
    gout <= 2'b10;
    goe  <= 2'b11;
    repeat (3) @(posedge clk);
    chk({30'h0, pin}, 32'h2, "gpio pin value");
    alt <= 2'b11;
    tgt[0].pos <= 12'h002;
    repeat (8) @(posedge clk);
    chk({28'h0, pin, pin_oe}, 32'hF, "alt pin");
    tgt[0].pos <= 12'h000;
    repeat (8) @(posedge clk);
    chk({30'h0, pin}, 32'h2, "alt pin low");
    // separate edges: interrupt on rise, trigger on fall, slow source
    wr(ACC_OFF_CTL0 + ACC_OFF_CHSTEP, 32'h008);
    wr(ACC_OFF_CTL0, 32'h828);
    wr(ACC_OFF_MIS, 32'h3);
    bus(1'b0, ACC_OFF_RIS, 32'h0, q);
    chk(q, 32'h0, "raw cleared");
    t0 = tcnt[0];
    lag <= 4'h3;
    tgt[0].neg <= 12'h000;
    tgt[0].pos <= 12'h0C8;
    repeat (12) @(posedge clk);
    bus(1'b0, ACC_OFF_RIS, 32'h0, q);
    chk(q, 32'h1, "raw on rise");
    chk({31'h0, irq}, 32'h0, "masked irq");
    chk({24'h0, tcnt[0]}, {24'h0, t0}, "no trigger on rise");
    wr(ACC_OFF_INTEN, 32'h1);
    chk({31'h0, irq}, 32'h1, "enabled irq");
    wr(ACC_OFF_MIS, 32'h0);
    bus(1'b0, ACC_OFF_MIS, 32'h0, q);
    chk(q, 32'h1, "write zero keeps");
    wr(ACC_OFF_MIS, 32'h1);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    tgt[0].pos <= 12'h000;
    repeat (12) @(posedge clk);
    chk({24'h0, tcnt[0]}, {24'h0, t0 + 8'h01}, "trigger on fall");
    bus(1'b0, ACC_OFF_RIS, 32'h0, q);
    chk(q, 32'h0, "no irq on fall");
    // prompt source: two sync stages before the event
    lag <= 4'h0;
    tgt[0].pos <= 12'h0C8;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq not before sync");
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq after sync");
    // both-edge interrupt sense, exercised on a falling result
    wr(ACC_OFF_CTL0, 32'h00C);
    wr(ACC_OFF_MIS, 32'h1);
    tgt[0].pos <= 12'h000;
    repeat (6) @(posedge clk);
    bus(1'b0, ACC_OFF_RIS, 32'h0, q);
    chk(q, 32'h1, "both edges on fall");
    results();
  end

endmodule

`default_nettype wire
